// [src/output_channel_map.svh]
`ifndef OUTPUT_CHANNEL_MAP_SVH
`define OUTPUT_CHANNEL_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SYNC_MASK_ADDR   16'h0436
`define OUT_CFG_ADDR     16'h0437
`define DIV_LOW_ADDR     16'h0438
`define DIV_HIGH_ADDR    16'h0439
`define DIV_PHASE_ADDR   16'h043a
`define CHAN_STATUS_ADDR 16'h043f

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CFG_INVERT_BIT   0
`define CFG_MODE_LSB     1
`define CFG_MODE_MSB     2
`define MASK_BIT         0
`define DIV_LOW_MSB      7
`define DIV_HIGH_MSB     1
`define PHASE_MSB        5
`define DIV_W            10
`define PHASE_W          6
`define STAT_RUN_BIT     0
`define STAT_CLK_BIT     1
`define STAT_EN_BIT      2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET        8'h00
`define CFG_INVERT_RESET 1'h0
`define CFG_MODE_RESET   2'h0
`define DIV_LOW_RESET    8'h00
`define DIV_HIGH_RESET   2'h0
`define PHASE_RESET      6'h00
`define MASK_RESET       1'h0

`endif

// [src/output_channel_pkg.sv]
`include "output_channel_map.svh"

package output_channel_pkg;

    typedef enum logic [1:0] {
        DRIVE_LOW,
        DRIVE_MID,
        DRIVE_HIGH,
        DRIVE_OFF
    } drive_mode_t;

    typedef enum logic [1:0] {
        DIV_HELD,
        DIV_PHASE_WAIT,
        DIV_COUNTING
    } div_state_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_MASK,
        SEL_CFG,
        SEL_DIVLO,
        SEL_DIVHI,
        SEL_PHASE,
        SEL_STATUS
    } reg_sel_t;

    typedef struct packed {
        div_state_t            state;
        logic [`DIV_W-1:0]     cnt;
        logic [`PHASE_W-1:0]   delay;
        logic                  divClk;
    } core_state_t;

    typedef struct packed {
        logic                  syncMask;
        logic                  invert;
        logic [1:0]            mode;
        logic [7:0]            divLow;
        logic [1:0]            divHigh;
        logic [`PHASE_W-1:0]   phase;
        logic [7:0]            rdData;
        logic                  clkOut;
        logic                  clkOutEn;
        drive_mode_t           driveMode;
    } top_state_t;

endpackage

// [src/first_channel_divider_core.sv]
`include "output_channel_map.svh"

module first_channel_divider_core
(
    input  wire logic                clk,       // System clock
    input  wire logic                rst,       // Async reset, high
    input  wire logic                prescEdge, // Prescaler edge tick
    input  wire logic                syncPulse, // Sync event pulse
    input  wire logic                syncMask,  // Ignore sync, run
    input  wire logic [`DIV_W-1:0]   divRatio,  // Divide value
    input  wire logic [`PHASE_W-1:0] initPhase, // Half-tick offset
    output logic                     divClk,    // Divided clock
    output logic                     running    // Not held
);
    import output_channel_pkg::*;

    core_state_t state_reg;
    core_state_t state_next;

    // ------------------------------------------------------------
    // Counter on half periods of the prescaler output
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg.state)
            DIV_HELD:
            begin
                if (syncMask)
                begin
                    state_next.state = DIV_COUNTING;
                end
            end
            DIV_PHASE_WAIT:
            begin
                if (prescEdge)
                begin
                    state_next.delay = state_reg.delay - 1'b1;
                    if (state_reg.delay <= `PHASE_W'(1))
                    begin
                        state_next.state = DIV_COUNTING;
                    end
                end
            end
            DIV_COUNTING:
            begin
                // Toggle every ratio+1 edges: full period is ratio+1
                // input periods; >= keeps a shrunk ratio safe
                if (prescEdge)
                begin
                    if (state_reg.cnt >= divRatio)
                    begin
                        state_next.cnt    = '0;
                        state_next.divClk = ~state_reg.divClk;
                    end
                    else
                    begin
                        state_next.cnt = state_reg.cnt + 1'b1;
                    end
                end
            end
            default:
            begin
                state_next.state = DIV_HELD;
            end
        endcase
        // Unmasked sync restarts from the programmed phase
        if (syncPulse && !syncMask)
        begin
            state_next.cnt    = '0;
            state_next.divClk = 1'b0;
            state_next.delay  = initPhase;
            if (initPhase == '0)
            begin
                state_next.state = DIV_COUNTING;
            end
            else
            begin
                state_next.state = DIV_PHASE_WAIT;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '{DIV_HELD, '0, '0, 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign divClk  = state_reg.divClk;
    assign running = (state_reg.state != DIV_HELD);

endmodule

// [src/output_channel_divider_a.sv]
// Contract
// - Mode bits 2:1 pick drive; 11 tristates
// - Bit 0 inverts output clock polarity
// - Divide ratio is ten-bit value plus one
// - Low byte, then high two bits
// - Six-bit start phase in half periods
// - Divider clocked from prescaler output edges
// - Reset clears ratio and phase to zero
// - Mask releases divider and ignores syncs

`include "output_channel_map.svh"

module output_channel_divider_a
(
    input  wire logic                      clk,       // 200 MHz clock
    input  wire logic                      rst,       // Async reset, high
    input  wire logic [15:0]               regAddr,   // Register address
    input  wire logic [7:0]                regWrData, // Write data
    input  wire logic                      regWr,     // Write strobe
    input  wire logic                      regRd,     // Read strobe
    output logic [7:0]                     regRdData, // Read data, +1 cycle
    input  wire logic                      prescEdge, // Prescaler edge tick
    input  wire logic                      syncPulse, // Sync event pulse
    output logic                           clkOut,    // Output clock
    output logic                           clkOutEn,  // Output driven
    output output_channel_pkg::drive_mode_t driveMode // Drive strength
);
    import output_channel_pkg::*;

    top_state_t state_reg;
    top_state_t state_next;

    logic                divClk;
    logic                running;
    logic [`DIV_W-1:0]   divRatio;
    reg_sel_t            wrSel;
    reg_sel_t            rdSel;
    drive_mode_t         modeSel;

    // ------------------------------------------------------------
    // Address decode, shared by write and read paths
    // ------------------------------------------------------------
    function automatic reg_sel_t decodeReg(input logic [15:0] addr);
        reg_sel_t sel;
        if (addr == `SYNC_MASK_ADDR)
        begin
            sel = SEL_MASK;
        end
        else if (addr == `OUT_CFG_ADDR)
        begin
            sel = SEL_CFG;
        end
        else if (addr == `DIV_LOW_ADDR)
        begin
            sel = SEL_DIVLO;
        end
        else if (addr == `DIV_HIGH_ADDR)
        begin
            sel = SEL_DIVHI;
        end
        else if (addr == `DIV_PHASE_ADDR)
        begin
            sel = SEL_PHASE;
        end
        else if (addr == `CHAN_STATUS_ADDR)
        begin
            sel = SEL_STATUS;
        end
        else
        begin
            sel = SEL_NONE;
        end
        return sel;
    endfunction

    assign wrSel    = decodeReg(regAddr);
    assign rdSel    = decodeReg(regAddr);
    assign divRatio = {state_reg.divHigh, state_reg.divLow};
    assign modeSel  = drive_mode_t'(state_reg.mode);

    // ------------------------------------------------------------
    // Divider core
    // ------------------------------------------------------------
    first_channel_divider_core u_core
    (
        .clk       (clk),
        .rst       (rst),
        .prescEdge (prescEdge),
        .syncPulse (syncPulse),
        .syncMask  (state_reg.syncMask),
        .divRatio  (divRatio),
        .initPhase (state_reg.phase),
        .divClk    (divClk),
        .running   (running)
    );

    // ------------------------------------------------------------
    // Register file, read port and output stage
    // ------------------------------------------------------------
    always_comb
    begin
        state_next        = state_reg;
        state_next.rdData = 8'h00;

        if (regWr)
        begin
            case (wrSel)
                SEL_MASK:
                begin
                    state_next.syncMask = regWrData[`MASK_BIT];
                end
                SEL_CFG:
                begin
                    state_next.invert = regWrData[`CFG_INVERT_BIT];
                    state_next.mode   =
                        regWrData[`CFG_MODE_MSB:`CFG_MODE_LSB];
                end
                SEL_DIVLO:
                begin
                    state_next.divLow =
                        regWrData[`DIV_LOW_MSB:0];
                end
                SEL_DIVHI:
                begin
                    state_next.divHigh =
                        regWrData[`DIV_HIGH_MSB:0];
                end
                SEL_PHASE:
                begin
                    state_next.phase = regWrData[`PHASE_MSB:0];
                end
                default:
                begin
                    // Status and unmapped writes are dropped
                    state_next.rdData = 8'h00;
                end
            endcase
        end

        if (regRd)
        begin
            case (rdSel)
                SEL_MASK:
                begin
                    state_next.rdData[`MASK_BIT] = state_reg.syncMask;
                end
                SEL_CFG:
                begin
                    state_next.rdData[`CFG_INVERT_BIT] = state_reg.invert;
                    state_next.rdData[`CFG_MODE_MSB:`CFG_MODE_LSB] =
                        state_reg.mode;
                end
                SEL_DIVLO:
                begin
                    state_next.rdData = state_reg.divLow;
                end
                SEL_DIVHI:
                begin
                    state_next.rdData[`DIV_HIGH_MSB:0] = state_reg.divHigh;
                end
                SEL_PHASE:
                begin
                    state_next.rdData[`PHASE_MSB:0] = state_reg.phase;
                end
                SEL_STATUS:
                begin
                    state_next.rdData[`STAT_RUN_BIT] = running;
                    state_next.rdData[`STAT_CLK_BIT] = divClk;
                    state_next.rdData[`STAT_EN_BIT]  = state_reg.clkOutEn;
                end
                default:
                begin
                    state_next.rdData = 8'h00;
                end
            endcase
        end

        // Output pins follow the divider one cycle later
        state_next.driveMode = modeSel;
        case (modeSel)
            DRIVE_OFF:
            begin
                // Powered down: pin released, level parked low
                state_next.clkOutEn = 1'b0;
                state_next.clkOut   = 1'b0;
            end
            default:
            begin
                state_next.clkOutEn = 1'b1;
                state_next.clkOut   = divClk ^ state_reg.invert;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.syncMask  <= `MASK_RESET;
            state_reg.invert    <= `CFG_INVERT_RESET;
            state_reg.mode      <= `CFG_MODE_RESET;
            state_reg.divLow    <= `DIV_LOW_RESET;
            state_reg.divHigh   <= `DIV_HIGH_RESET;
            state_reg.phase     <= `PHASE_RESET;
            state_reg.rdData    <= 8'h00;
            state_reg.clkOut    <= 1'b0;
            state_reg.clkOutEn  <= 1'b1;
            state_reg.driveMode <= DRIVE_LOW;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign regRdData = state_reg.rdData;
    assign clkOut    = state_reg.clkOut;
    assign clkOutEn  = state_reg.clkOutEn;
    assign driveMode = state_reg.driveMode;

endmodule

// [dv/output_channel_checker.sv]
`include "output_channel_map.svh"

module output_channel_checker
(
    input wire logic                            clk,       // Clock
    input wire logic                            rst,       // Reset, high
    input wire logic [15:0]                     regAddr,   // Address
    input wire logic [7:0]                      regWrData, // Write data
    input wire logic                            regWr,     // Write strobe
    input wire logic                            regRd,     // Read strobe
    input wire logic [7:0]                      regRdData, // Read data
    input wire logic                            prescEdge, // Prescaler tick
    input wire logic                            syncPulse, // Sync event
    input wire logic                            clkOut,    // Output clock
    input wire logic                            clkOutEn,  // Output enable
    input wire output_channel_pkg::drive_mode_t driveMode  // Drive
);
    import output_channel_pkg::*;
    logic maskReg;
    logic invReg;
    logic armedReg;

    // Shadow of mask and polarity; armed is conservative on any mask write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            maskReg  <= 1'b0;
            invReg   <= 1'b0;
            armedReg <= 1'b0;
        end
        else
        begin
            if (regWr && regAddr == `SYNC_MASK_ADDR)
                maskReg <= regWrData[0];
            if (regWr && regAddr == `OUT_CFG_ADDR)
                invReg <= regWrData[0];
            if (syncPulse || (regWr && regAddr == `SYNC_MASK_ADDR))
                armedReg <= 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_MODE_EN: assert property (
        clkOutEn == (driveMode != DRIVE_OFF))
        else $error("Enable does not follow drive mode");
    AST_MODE_OFF: assert property (
        driveMode == DRIVE_OFF |-> !clkOut)
        else $error("Clock active while powered down");
    AST_MODE_WR: assert property (
        regWr && regAddr == `OUT_CFG_ADDR
        |-> ##2 driveMode == $past(regWrData[2:1], 2))
        else $error("Drive mode does not follow write");
    AST_RESET: assert property (
        $past(rst) |-> !clkOut && clkOutEn && driveMode == DRIVE_LOW
        && regRdData == 8'h00)
        else $error("Wrong state after reset");
    AST_HELD: assert property (
        !armedReg && clkOutEn && !$past(regWr) && !$past(regWr, 2)
        |-> $stable(clkOut))
        else $error("Divider moved before sync");
    AST_TOGGLE_SRC: assert property (
        $changed(clkOut) && !$past(regWr) && !$past(regWr, 2)
        |-> $past(prescEdge, 2) || $past(syncPulse, 2))
        else $error("Output edge without prescaler tick");
    AST_MASK_IGNORE: assert property (
        maskReg && syncPulse && !prescEdge && !regWr && !$past(regWr)
        |-> ##2 $stable(clkOut))
        else $error("Masked sync moved the output");
    AST_SYNC_RESTART: assert property (
        !maskReg && syncPulse && !regWr && !$past(regWr)
        |-> ##2 clkOut == ($past(invReg) & clkOutEn))
        else $error("Sync did not restart divider");
    AST_RD_HIGH: assert property (
        regRd && regAddr == `DIV_HIGH_ADDR |=> regRdData[7:2] == 6'h00)
        else $error("Reserved ratio bits read nonzero");
endmodule

bind output_channel_divider_a output_channel_checker chk_u
(
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .prescEdge(prescEdge),
    .syncPulse(syncPulse),
    .clkOut(clkOut),
    .clkOutEn(clkOutEn),
    .driveMode(driveMode)
);

// [dv/clock_receiver_model.sv]
module clock_receiver_model
(
    input  wire logic        clk,      // Sampling clock
    input  wire logic        rst,      // Reset, high
    input  wire logic        clkOut,   // Driven clock
    input  wire logic        clkOutEn, // Driver enable
    output logic      [15:0] toggles,  // Edges seen
    output logic      [15:0] gap       // Cycles between last edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        prevLine;
    logic [15:0] cnt;
    logic        lineIn;

    // Undriven pair floats: seen as a line that flips every cycle
    assign lineIn = clkOutEn ? clkOut : ~prevLine;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prevLine <= 1'b0;
            cnt      <= 16'h0000;
            toggles  <= 16'h0000;
            gap      <= 16'h0000;
        end
        else
        begin
            prevLine <= lineIn;
            cnt      <= cnt + 16'h0001;
            if (clkOutEn && lineIn != prevLine)
            begin
                toggles <= toggles + 16'h0001;
                gap     <= cnt;
                cnt     <= 16'h0001;
            end
        end
    end
endmodule

// [dv/tb_top.sv]
`include "output_channel_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import output_channel_pkg::*;
    logic        clk;
    logic        rst;
    logic [15:0] regAddr;
    logic [7:0]  regWrData;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdData;
    logic        prescEdge;
    logic        syncPulse;
    logic        clkOut;
    logic        clkOutEn;
    drive_mode_t driveMode;
    logic [15:0] toggles;
    logic [15:0] gap;
    logic [31:0] seed;
    int          err_count;
    int          n_tests;

    output_channel_divider_a dut_u (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .prescEdge(prescEdge),
        .syncPulse(syncPulse), .clkOut(clkOut), .clkOutEn(clkOutEn),
        .driveMode(driveMode));
    clock_receiver_model rx_u (.clk(clk), .rst(rst), .clkOut(clkOut),
        .clkOutEn(clkOutEn), .toggles(toggles), .gap(gap));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] rw_mask(input logic [15:0] a);
        case (a)
            `OUT_CFG_ADDR:   return 8'h07;
            `DIV_LOW_ADDR:   return 8'hff;
            `DIV_HIGH_ADDR:  return 8'h03;
            `DIV_PHASE_ADDR: return 8'h3f;
            default:         return 8'h00;
        endcase
    endfunction

    function automatic logic [15:0] first_gap(input logic [9:0] r,
                                              input logic [5:0] p);
        return {6'h00, r} + {10'h000, p} + 16'h0002;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic edges_to_change(input logic lvl, output logic [15:0] n);
        n = 16'h0000;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (clkOut === lvl && n < 16'd3000);
    endtask

    task automatic pulse_sync();
        @(posedge clk);
        prescEdge <= 1'b0;
        syncPulse <= 1'b1;
        @(posedge clk);
        syncPulse <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic run_div(input logic [9:0] r, input logic [5:0] p,
                           input logic inv);
        logic [15:0] n;
        logic [15:0] t0;
        wr(`DIV_LOW_ADDR, r[7:0]);
        wr(`DIV_HIGH_ADDR, {6'h00, r[9:8]});
        wr(`DIV_PHASE_ADDR, {2'h0, p});
        wr(`OUT_CFG_ADDR, {7'h00, inv});
        pulse_sync();
        chk(clkOut, inv, "level after sync");
        @(posedge clk);
        prescEdge <= 1'b1;
        edges_to_change(inv, n);
        chk(n, first_gap(r, p), "first edge");
        t0 = toggles;
        edges_to_change(clkOut, n);
        chk(n, {6'h00, r} + 16'h0001, "half period cycles");
        // Receiver registers the line: its view lags one cycle
        @(posedge clk);
        #1;
        chk(gap, {6'h00, r} + 16'h0001, "half period");
        chk(toggles - t0, 16'h0002, "receiver edges");
        @(posedge clk);
        prescEdge <= 1'b0;
        $display("Test divider r=%0d p=%0d inv=%0d done", r, p, inv);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [15:0] addrs [5];
        logic [7:0]  d;
        logic [31:0] v;
        logic [15:0] n;
        addrs = '{`OUT_CFG_ADDR, `DIV_LOW_ADDR, `DIV_HIGH_ADDR,
                  `DIV_PHASE_ADDR, 16'h0500};
        seed = 32'h4484;
        err_count = 0;
        n_tests = 0;
        {rst, regAddr, regWrData, regWr, regRd, prescEdge, syncPulse} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        prescEdge <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk(clkOut, 1'b0, "held before sync");
        @(posedge clk);
        prescEdge <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rd(addrs[i], d);
            chk(d, 8'h00, "reset value");
            v = rnd();
            wr(addrs[i], v[7:0]);
            rd(addrs[i], d);
            chk(d, v[7:0] & rw_mask(addrs[i]), "readback");
            @(posedge clk);
            #1;
            chk(regRdData, 8'h00, "read data held too long");
        end
        $display("Test registers done");
        for (int m = 0; m < 4; m++)
        begin
            wr(`OUT_CFG_ADDR, {5'h00, m[1:0], 1'b0});
            repeat (2) @(posedge clk);
            #1;
            chk(driveMode, m[1:0], "drive mode");
            chk(clkOutEn, (m != 3) ? 16'h1 : 16'h0, "enable");
        end
        $display("Test modes done");
        run_div(10'd0, 6'd0, 1'b0);
        run_div(10'd0, 6'd1, 1'b1);
        run_div(10'd1023, 6'd63, 1'b0);
        run_div(10'd1, 6'd0, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            v = rnd();
            run_div(v[9:0], v[15:10], v[16]);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(`SYNC_MASK_ADDR, 8'h01);
        @(posedge clk);
        prescEdge <= 1'b1;
        @(posedge clk);
        prescEdge <= 1'b0;
        edges_to_change(1'b0, n);
        chk(n, 16'h0001, "mask release, divide by one");
        pulse_sync();
        chk(clkOut, 1'b1, "masked sync ignored");
        rd(`SYNC_MASK_ADDR, d);
        chk(d, 8'h01, "mask readback");
        rd(`CHAN_STATUS_ADDR, d);
        chk(d, 8'h07, "status running");
        $display("Test mask done");
        give_verdict();
    end

    initial
    begin
        // Eight divider runs of at most about 2200 cycles each
        repeat (25000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
